// >>> src/pattern_exposure_sequencer.sv
`default_nettype none
module pattern_exposure_sequencer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic vsync_in,
  input wire logic [pattern_seq_pkg::WORD_W-1:0] pixel_word_in,
  input wire logic pattern_advance_in,
  input wire logic flash_word_valid,
  input wire logic [pattern_seq_pkg::WORD_W-1:0] flash_word,
  output logic flash_load_req,
  output logic frame_trigger_out,
  output logic pattern_trigger_out,
  output logic pattern_ready_out,
  output logic [2:0] illum_en,
  output logic mirror_on,
  output logic [4:0] mirror_plane,
  output logic [pattern_seq_pkg::WORD_W-1:0] line_value,
  output logic replicate_rows
);
  localparam int TW = pattern_seq_pkg::TIME_W;
  localparam int WW = pattern_seq_pkg::WORD_W;
  localparam int CW = pattern_seq_pkg::CNT_W;
  localparam int FW = pattern_seq_pkg::FT_CNT_W;

  // Pin synchronisers
  logic [1:0] vs_sync_q, adv_sync_q;
  logic [WW-1:0] px_s1_q, px_s2_q;
  logic vs_prev_q, adv_prev_q;

  // Configuration
  logic en_q, rows_q;
  pattern_seq_pkg::mode_t mode_q;
  logic [1:0] ill_sel_q;
  logic [CW-1:0] count_q;
  logic [TW-1:0] pre_q, ill_q, post_q, fdly_q, pdly_q;

  // Sequencer
  pattern_seq_pkg::seq_state_t st_q, st_d;
  logic [TW-1:0] cnt_q, cnt_d, ptime_q;
  logic [4:0] idx_q, idx_d, ld_idx_q;
  logic [WW-1:0] word_q;
  logic loaded_q, fev_d;
  logic [7:0] frames_q;
  logic fd_busy_q;
  logic [TW-1:0] fd_cnt_q;
  logic [FW-1:0] ft_cnt_q, ft_cnt_d;
  logic [WW-1:0] mem_rd;

  wire vs_edge = vs_sync_q[1] & ~vs_prev_q;
  wire adv_edge = adv_sync_q[1] & ~adv_prev_q;
  wire is_ext = mode_q == pattern_seq_pkg::MODE_EXT_1BIT;
  wire is_free = mode_q == pattern_seq_pkg::MODE_FREE_RUN;
  wire is_trig = mode_q == pattern_seq_pkg::MODE_PATTERN_ADVANCE_IN;
  wire ext_start = en_q & is_ext & vs_edge;
  wire adv_take = en_q & is_trig & pattern_ready_out & adv_edge;
  wire wr_cmd = reg_wr & (reg_addr == pattern_seq_pkg::REG_CMD);
  wire load_go = wr_cmd & reg_wdata[pattern_seq_pkg::CMD_LOAD_BIT] & en_q & ~is_ext;
  wire [CW-1:0] cap = is_ext ? pattern_seq_pkg::MAX_BIT_PATTERNS
                             : pattern_seq_pkg::MAX_LINE_PATTERNS;
  wire [CW-1:0] cnt_clip = (count_q > cap) ? cap : count_q;
  wire [CW-1:0] count_eff = (cnt_clip == '0) ? 6'h01 : cnt_clip;
  wire [4:0] last_idx = 5'(count_eff - 6'h01);
  wire last_pat = idx_q == last_idx;
  wire [TW-1:0] pre_len = (pre_q == '0) ? '0 : pre_q - 16'h0001;
  wire [TW-1:0] ill_len = (ill_q == '0) ? '0 : ill_q - 16'h0001;
  wire [TW-1:0] post_len = (post_q == '0) ? '0 : post_q - 16'h0001;
  wire cnt_done = cnt_q == '0;
  wire ld_write = (st_q == pattern_seq_pkg::ST_LOAD) & flash_word_valid;
  wire ld_last = ld_write & (ld_idx_q == last_idx);
  wire fd_fire = fd_busy_q & (fd_cnt_q == '0);
  wire lit_phase = (st_q == pattern_seq_pkg::ST_PRE) | (st_q == pattern_seq_pkg::ST_ILLUM);
  wire [2:0] ill_onehot = 3'(3'h1 << ill_sel_q);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vs_sync_q <= '0;
      adv_sync_q <= '0;
      px_s1_q <= '0;
      px_s2_q <= '0;
      vs_prev_q <= 1'b0;
      adv_prev_q <= 1'b0;
    end else begin
      vs_sync_q <= {vs_sync_q[0], vsync_in};
      adv_sync_q <= {adv_sync_q[0], pattern_advance_in};
      px_s1_q <= pixel_word_in;
      px_s2_q <= px_s1_q;
      vs_prev_q <= vs_sync_q[1];
      adv_prev_q <= adv_sync_q[1];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_q <= 1'b0;
      mode_q <= pattern_seq_pkg::MODE_EXT_1BIT;
      rows_q <= 1'b0;
      ill_sel_q <= pattern_seq_pkg::ILL_SEL_RST;
      count_q <= pattern_seq_pkg::COUNT_RST;
      pre_q <= pattern_seq_pkg::TIME_RST;
      ill_q <= pattern_seq_pkg::TIME_RST;
      post_q <= pattern_seq_pkg::TIME_RST;
      fdly_q <= '0;
      pdly_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        pattern_seq_pkg::REG_CTRL: begin
          en_q <= reg_wdata[pattern_seq_pkg::CTRL_EN_BIT];
          mode_q <= pattern_seq_pkg::mode_t'(reg_wdata[pattern_seq_pkg::CTRL_MODE_LSB +: 2]);
          rows_q <= reg_wdata[pattern_seq_pkg::CTRL_ROWS_BIT];
          ill_sel_q <= reg_wdata[pattern_seq_pkg::CTRL_ILL_LSB +: 2];
        end
        pattern_seq_pkg::REG_COUNT: count_q <= reg_wdata[CW-1:0];
        pattern_seq_pkg::REG_PRE: pre_q <= reg_wdata[TW-1:0];
        pattern_seq_pkg::REG_ILLUM: ill_q <= reg_wdata[TW-1:0];
        pattern_seq_pkg::REG_POST: post_q <= reg_wdata[TW-1:0];
        pattern_seq_pkg::REG_FDLY: fdly_q <= reg_wdata[TW-1:0];
        pattern_seq_pkg::REG_PDLY: pdly_q <= reg_wdata[TW-1:0];
        default: ;
      endcase
    end
  end

  // Pattern sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_done ? '0 : cnt_q - 16'h0001;
    idx_d = idx_q;
    fev_d = 1'b0;
    case (st_q)
      pattern_seq_pkg::ST_IDLE: begin
        if (adv_take) begin
          st_d = pattern_seq_pkg::ST_PRE;
          cnt_d = pre_len;
          fev_d = 1'b1;
        end else if (load_go) begin
          st_d = pattern_seq_pkg::ST_LOAD;
        end
      end
      pattern_seq_pkg::ST_LOAD: begin
        if (ld_last) begin
          idx_d = '0;
          if (is_free) begin
            st_d = pattern_seq_pkg::ST_PRE;
            cnt_d = pre_len;
            fev_d = 1'b1;
          end else begin
            st_d = pattern_seq_pkg::ST_IDLE;
          end
        end
      end
      pattern_seq_pkg::ST_PRE: begin
        if (cnt_done) begin
          st_d = pattern_seq_pkg::ST_ILLUM;
          cnt_d = ill_len;
        end
      end
      pattern_seq_pkg::ST_ILLUM: begin
        if (cnt_done) begin
          st_d = pattern_seq_pkg::ST_POST;
          cnt_d = post_len;
        end
      end
      pattern_seq_pkg::ST_POST: begin
        if (cnt_done) begin
          idx_d = last_pat ? '0 : idx_q + 5'h01;
          cnt_d = pre_len;
          if (is_trig) begin
            st_d = pattern_seq_pkg::ST_IDLE;
          end else if (is_ext && last_pat) begin
            st_d = pattern_seq_pkg::ST_PAD;
          end else begin
            st_d = pattern_seq_pkg::ST_PRE;
            fev_d = last_pat;
          end
        end
      end
      pattern_seq_pkg::ST_PAD: st_d = is_ext ? pattern_seq_pkg::ST_PAD : pattern_seq_pkg::ST_IDLE;
      default: st_d = pattern_seq_pkg::ST_IDLE;
    endcase
    if (ext_start) begin
      st_d = pattern_seq_pkg::ST_PRE;
      cnt_d = pre_len;
      idx_d = '0;
      fev_d = 1'b1;
    end
    if (!en_q) begin
      st_d = pattern_seq_pkg::ST_IDLE;
      idx_d = '0;
      fev_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= pattern_seq_pkg::ST_IDLE;
      cnt_q <= '0;
      idx_q <= '0;
      ld_idx_q <= '0;
      loaded_q <= 1'b0;
      word_q <= '0;
      frames_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      if (ext_start) begin
        word_q <= px_s2_q;
      end
      if (load_go && st_q == pattern_seq_pkg::ST_IDLE) begin
        ld_idx_q <= '0;
        loaded_q <= 1'b0;
      end else if (ld_write) begin
        ld_idx_q <= ld_idx_q + 5'h01;
        loaded_q <= ld_last;
      end
      if (fev_d) begin
        frames_q <= frames_q + 8'h01;
      end
    end
  end

  pattern_line_mem u_mem (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(ld_write),
    .wr_addr(ld_idx_q),
    .wr_data(flash_word),
    .rd_addr(idx_q),
    .rd_data_q(mem_rd)
  );

  // Frame trigger delay and pulse
  assign ft_cnt_d = fd_fire ? pattern_seq_pkg::FT_MIN_LOAD
                  : (ft_cnt_q == '0) ? '0 : ft_cnt_q - 10'h001;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fd_busy_q <= 1'b0;
      fd_cnt_q <= '0;
      ft_cnt_q <= '0;
    end else begin
      ft_cnt_q <= ft_cnt_d;
      if (fev_d) begin
        fd_busy_q <= 1'b1;
        fd_cnt_q <= fdly_q;
      end else if (fd_fire) begin
        fd_busy_q <= 1'b0;
      end else if (fd_busy_q) begin
        fd_cnt_q <= fd_cnt_q - 16'h0001;
      end
    end
  end

  // Pattern time since pattern start
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ptime_q <= '0;
    end else if ((st_d == pattern_seq_pkg::ST_PRE && st_q != pattern_seq_pkg::ST_PRE)
                 || ext_start) begin
      ptime_q <= '0;
    end else if (ptime_q != '1) begin
      ptime_q <= ptime_q + 16'h0001;
    end
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frame_trigger_out <= 1'b0;
      pattern_trigger_out <= 1'b0;
      pattern_ready_out <= 1'b0;
      illum_en <= '0;
      mirror_on <= 1'b0;
      mirror_plane <= '0;
      line_value <= '0;
      replicate_rows <= 1'b0;
      flash_load_req <= 1'b0;
    end else begin
      frame_trigger_out <= ft_cnt_d != '0;
      pattern_trigger_out <= lit_phase && ptime_q >= pdly_q;
      pattern_ready_out <= en_q & is_trig & loaded_q & ~adv_take
                           & (st_d == pattern_seq_pkg::ST_IDLE);
      illum_en <= (st_q == pattern_seq_pkg::ST_ILLUM) ? ill_onehot : '0;
      mirror_on <= st_q == pattern_seq_pkg::ST_ILLUM;
      mirror_plane <= idx_q;
      line_value <= is_ext ? word_q : mem_rd;
      replicate_rows <= rows_q;
      flash_load_req <= st_d == pattern_seq_pkg::ST_LOAD;
    end
  end

  // Register read port
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        pattern_seq_pkg::REG_CTRL: reg_rdata <= {26'h000_0000, ill_sel_q, rows_q, mode_q, en_q};
        pattern_seq_pkg::REG_COUNT: reg_rdata <= {26'h000_0000, count_q};
        pattern_seq_pkg::REG_PRE: reg_rdata <= {16'h0000, pre_q};
        pattern_seq_pkg::REG_ILLUM: reg_rdata <= {16'h0000, ill_q};
        pattern_seq_pkg::REG_POST: reg_rdata <= {16'h0000, post_q};
        pattern_seq_pkg::REG_FDLY: reg_rdata <= {16'h0000, fdly_q};
        pattern_seq_pkg::REG_PDLY: reg_rdata <= {16'h0000, pdly_q};
        pattern_seq_pkg::REG_STATUS: reg_rdata <= {14'h0000, frames_q, idx_q, st_q,
                                                   loaded_q, pattern_ready_out};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Checks
  sequence s_pattern_start;
    st_q == pattern_seq_pkg::ST_PRE && $past(st_q) != pattern_seq_pkg::ST_PRE;
  endsequence
  sequence s_lit_entry;
    st_q == pattern_seq_pkg::ST_ILLUM && $past(st_q) == pattern_seq_pkg::ST_PRE;
  endsequence

  logic [FW:0] ft_hi_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ft_hi_q <= '0;
    end else begin
      // Saturates so a long merged pulse cannot wrap
      ft_hi_q <= !frame_trigger_out ? '0 : (ft_hi_q == '1) ? ft_hi_q : ft_hi_q + 11'h001;
    end
  end

  AST_FT_MIN_WIDTH: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(frame_trigger_out) |-> ft_hi_q >= 11'(pattern_seq_pkg::FT_MIN_CYC))
    else $error("frame trigger pulse too short");
  AST_FT_AFTER_DELAY: assert property (@(posedge mclk) disable iff (!nrst)
    fd_fire |=> frame_trigger_out [*8])
    else $error("frame trigger not raised after delay");
  AST_PT_LIT: assert property (@(posedge mclk) disable iff (!nrst)
    (s_lit_entry and (pdly_q <= pre_q)) |=> pattern_trigger_out)
    else $error("pattern trigger low while lit");
  AST_PT_DELAY: assert property (@(posedge mclk) disable iff (!nrst)
    (s_pattern_start and (pdly_q > 16'h0000)) |=> !pattern_trigger_out)
    else $error("pattern trigger ahead of its delay");
  AST_LED_ON: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == pattern_seq_pkg::ST_ILLUM |=> illum_en == $past(ill_onehot))
    else $error("illuminator not on for pattern");
  AST_DARK_PAD: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == pattern_seq_pkg::ST_PAD |=> !mirror_on && illum_en == 3'h0)
    else $error("light during padding");
  AST_MAX_PLANES: assert property (@(posedge mclk) disable iff (!nrst)
    is_ext |-> idx_q < 5'h18)
    else $error("bit plane index past limit");
  AST_ADV_IGNORED: assert property (@(posedge mclk) disable iff (!nrst)
    en_q && is_ext && adv_edge && !ext_start
    && (st_q == pattern_seq_pkg::ST_IDLE || st_q == pattern_seq_pkg::ST_PAD)
    |=> st_q == $past(st_q))
    else $error("advance honoured in external mode");
  AST_READY_DROP: assert property (@(posedge mclk) disable iff (!nrst)
    adv_take |=> (!pattern_ready_out && st_q == pattern_seq_pkg::ST_PRE) ##1 !pattern_ready_out)
    else $error("ready stays high after accepted advance");
endmodule
`default_nettype wire

// >>> src/pattern_seq_pkg.sv
`default_nettype none
package pattern_seq_pkg;
  // Clock and trigger timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int FT_MIN_NS = 20000;
  localparam int FT_MIN_CYC = (FT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FT_CNT_W = 10;
  localparam logic [FT_CNT_W-1:0] FT_MIN_LOAD = FT_CNT_W'(FT_MIN_CYC);

  // Widths and depths
  localparam int WORD_W = 24;
  localparam int TIME_W = 16;
  localparam int MEM_AW = 5;
  localparam int MEM_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] MAX_BIT_PATTERNS = 6'h18;
  localparam logic [CNT_W-1:0] MAX_LINE_PATTERNS = 6'h20;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] REG_PRE = 8'h08;
  localparam logic [7:0] REG_ILLUM = 8'h0C;
  localparam logic [7:0] REG_POST = 8'h10;
  localparam logic [7:0] REG_FDLY = 8'h14;
  localparam logic [7:0] REG_PDLY = 8'h18;
  localparam logic [7:0] REG_CMD = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;

  // Control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_ROWS_BIT = 3;
  localparam int CTRL_ILL_LSB = 4;
  localparam int CMD_LOAD_BIT = 0;

  // Values after reset
  localparam logic [CNT_W-1:0] COUNT_RST = 6'h18;
  localparam logic [TIME_W-1:0] TIME_RST = 16'h0001;
  localparam logic [1:0] ILL_SEL_RST = 2'h2;

  typedef enum logic [1:0] {
    MODE_EXT_1BIT = 2'h0,
    MODE_FREE_RUN = 2'h1,
    MODE_PATTERN_ADVANCE_IN = 2'h2
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PRE = 3'h1,
    ST_ILLUM = 3'h3,
    ST_POST = 3'h2,
    ST_PAD = 3'h6,
    ST_LOAD = 3'h4
  } seq_state_t;
endpackage
`default_nettype wire

// >>> src/pattern_line_mem.sv
`default_nettype none
module pattern_line_mem (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [pattern_seq_pkg::MEM_AW-1:0] wr_addr,
  input wire logic [pattern_seq_pkg::WORD_W-1:0] wr_data,
  input wire logic [pattern_seq_pkg::MEM_AW-1:0] rd_addr,
  output logic [pattern_seq_pkg::WORD_W-1:0] rd_data_q
);
  logic [pattern_seq_pkg::WORD_W-1:0] mem [pattern_seq_pkg::MEM_DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// >>> verification/sync_partner.sv
`default_nettype none
module sync_partner (
  input wire logic mclk,
  input wire logic flash_load_req,
  output logic vsync_in,
  output logic [pattern_seq_pkg::WORD_W-1:0] pixel_word_in,
  output logic pattern_advance_in,
  output logic flash_word_valid,
  output logic [pattern_seq_pkg::WORD_W-1:0] flash_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [pattern_seq_pkg::WORD_W-1:0] lines [32];
  int idx;
  initial begin
    vsync_in = 1'b0;
    pattern_advance_in = 1'b0;
    pixel_word_in = 24'h00_0000;
    flash_word_valid = 1'b0;
    flash_word = 24'h00_0000;
    idx = 0;
    for (int i = 0; i < 32; i++) lines[i] = 24'h13_5790 ^ 24'(24'h00_0421 * i);
  end
  // Stored lines streamed one word every other cycle while loading
  always @(posedge mclk) begin
    if (flash_load_req && !flash_word_valid) begin
      flash_word_valid <= 1'b1;
      flash_word <= lines[idx];
      idx <= idx + 1;
    end else begin
      flash_word_valid <= 1'b0;
      flash_word <= ~flash_word;
      if (!flash_load_req) idx <= 0;
    end
  end
  task automatic pulse_vsync(input logic [pattern_seq_pkg::WORD_W-1:0] w);
    @(posedge mclk);
    pixel_word_in <= w;
    vsync_in <= 1'b1;
    repeat (3) @(posedge mclk);
    vsync_in <= 1'b0;
  endtask
  task automatic pulse_advance();
    @(posedge mclk);
    pattern_advance_in <= 1'b1;
    repeat (3) @(posedge mclk);
    pattern_advance_in <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/pattern_exposure_sequencer_tb.sv
`default_nettype none
module pattern_exposure_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic vsync_in, pattern_advance_in, flash_word_valid, flash_load_req, frame_trigger_out;
  logic pattern_trigger_out, pattern_ready_out, mirror_on, replicate_rows;
  logic [2:0] illum_en, exp_illum;
  logic [4:0] mirror_plane;
  logic [23:0] pixel_word_in, flash_word, line_value;
  logic [23:0] exp_line [32];
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int lit_n, lit_len, pt_len, ft_len, gap, ft_fall_n, ft_rise_cyc, ev_cyc;
  int exp_ill, exp_pt, exp_gap, cnt_mod;
  bit gap_chk;
  logic mo_q, pt_q, ft_q, ev_q;
  // Pre, lit, post, count, pattern delay, frame delay, illuminator, word
  int rows [5][8] = '{'{2, 3, 2, 3, 1, 0, 2, 24'h00_0005}, '{1, 1, 1, 30, 0, 7, 0, 24'hA5_5A3C},
    '{3, 2, 1, 0, 3, 20, 1, 24'h80_0001}, '{1, 2, 1, 4, 0, 0, 2, 0}, '{10, 10, 10, 4, 0, 5, 0, 0}};
  logic [7:0] adr [6] = '{pattern_seq_pkg::REG_PRE, pattern_seq_pkg::REG_ILLUM,
    pattern_seq_pkg::REG_POST, pattern_seq_pkg::REG_COUNT, pattern_seq_pkg::REG_PDLY,
    pattern_seq_pkg::REG_FDLY};
  int rst_tab [10][2] = '{'{8'h00, 8'h20}, '{8'h04, 8'h18}, '{8'h08, 1}, '{8'h0C, 1},
    '{8'h10, 1}, '{8'h14, 0}, '{8'h18, 0}, '{8'h1C, 0}, '{8'h20, 0}, '{8'h24, 0}};

  always #12.5 mclk = ~mclk;

  pattern_exposure_sequencer dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .vsync_in, .pixel_word_in, .pattern_advance_in, .flash_word_valid, .flash_word,
    .flash_load_req, .frame_trigger_out, .pattern_trigger_out, .pattern_ready_out, .illum_en,
    .mirror_on, .mirror_plane, .line_value, .replicate_rows);
  sync_partner ptn (.mclk, .flash_load_req, .vsync_in, .pixel_word_in, .pattern_advance_in,
    .flash_word_valid, .flash_word);

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Kinds: 0 lit count, 1 frame trigger falls, 2 ready high, 3 frame trigger low
  task automatic wait_for(input int kind, input int n);
    int k;
    k = 0;
    while (!((kind == 0 && lit_n >= n) || (kind == 1 && ft_fall_n >= n)
        || (kind == 2 && pattern_ready_out === 1'b1) || (kind == 3 && frame_trigger_out === 1'b0))) begin
      @(posedge mclk);
      k++;
      if (k > 20000) begin
        mismatches++;
        $display("Error at %0t: wait kind %0d timed out", $time, kind);
        stop_test();
      end
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic configure(input int r);
    for (int i = 0; i < 6; i++) reg_write(adr[i], 32'(rows[r][i]));
    exp_ill = rows[r][1];
    exp_pt = rows[r][0] + rows[r][1] - rows[r][4];
    exp_gap = rows[r][2] + rows[r][0];
    cnt_mod = rows[r][3] > 24 ? 24 : (rows[r][3] == 0 ? 1 : rows[r][3]);
    exp_illum = 3'b001 << rows[r][6];
    lit_n = 0;
  endtask

  // Pulse timing monitor
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    mo_q <= mirror_on;
    pt_q <= pattern_trigger_out;
    ft_q <= frame_trigger_out;
    ev_q <= vsync_in | pattern_advance_in;
    if (nrst) begin
      if ((vsync_in | pattern_advance_in) && !ev_q) ev_cyc <= cyc;
      if (frame_trigger_out && !ft_q) ft_rise_cyc <= cyc;
      lit_len <= mirror_on ? lit_len + 1 : 0;
      pt_len <= pattern_trigger_out ? pt_len + 1 : 0;
      ft_len <= frame_trigger_out ? ft_len + 1 : 0;
      gap <= mirror_on ? 0 : gap + 1;
      check(illum_en, mirror_on ? exp_illum : 3'b000, "illuminator");
      if (mirror_on) check(pattern_trigger_out, 1'b1, "pattern trigger lit");
      if (mirror_on && !mo_q) begin
        if (gap_chk && lit_n > 0) check(gap, exp_gap, "dark gap");
        check(mirror_plane, lit_n % cnt_mod, "plane index");
        check(line_value, exp_line[mirror_plane], "line value");
        lit_n <= lit_n + 1;
      end
      if (!mirror_on && mo_q) begin
        check(lit_len, exp_ill, "lit length");
        check(pattern_trigger_out, 1'b0, "pattern trigger end");
      end
      if (!pattern_trigger_out && pt_q) check(pt_len, exp_pt, "pattern trigger length");
      if (!frame_trigger_out && ft_q) begin
        check(ft_len >= pattern_seq_pkg::FT_MIN_CYC, 1'b1, "frame trigger width");
        ft_fall_n <= ft_fall_n + 1;
      end
    end
  end

  initial begin
    logic [31:0] d;
    int l0, k;
    l0 = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    gap_chk = 1'b1;
    for (int r = 0; r < 3; r++) begin
      configure(r);
      for (int i = 0; i < 32; i++) exp_line[i] = 24'(rows[r][7]);
      reg_write(pattern_seq_pkg::REG_CTRL, 32'(1 + (rows[r][6] << 4)));
      k = ft_fall_n;
      ptn.pulse_vsync(24'(rows[r][7]));
      wait_for(1, k + 1);
      if (r == 0) l0 = ft_rise_cyc - ev_cyc;
      check(ft_rise_cyc - ev_cyc, l0 + rows[r][5], "frame trigger delay");
      check(lit_n, cnt_mod, "pattern count");
      reg_read(pattern_seq_pkg::REG_STATUS, d);
      check(d[4:2], 3'h6, "pad state");
      reg_read(pattern_seq_pkg::REG_PRE, d);
      check(d, rows[r][0], "pre readback");
    end
    k = lit_n;
    ptn.pulse_advance();
    repeat (20) @(posedge mclk);
    check(lit_n, k, "advance in external mode");
    check(pattern_ready_out, 1'b0, "ready in external mode");
    gap_chk = 1'b0;
    configure(3);
    for (int i = 0; i < 32; i++) exp_line[i] = ptn.lines[i];
    reg_write(pattern_seq_pkg::REG_CTRL, 32'h0000_002B);
    reg_write(pattern_seq_pkg::REG_CMD, 32'h0000_0001);
    wait_for(0, 9);
    check(replicate_rows, 1'b1, "row replication");
    check(frame_trigger_out, 1'b1, "free-run frame trigger");
    reg_read(pattern_seq_pkg::REG_STATUS, d);
    check(d[1], 1'b1, "loaded flag");
    check(d[17:10], 8'h06, "frame count");
    // Lands the disable in a dark post interval
    repeat (3) @(posedge mclk);
    reg_write(pattern_seq_pkg::REG_CTRL, 32'h0000_0000);
    wait_for(3, 0);
    configure(4);
    reg_write(pattern_seq_pkg::REG_CTRL, 32'h0000_0005);
    reg_write(pattern_seq_pkg::REG_CMD, 32'h0000_0001);
    // Ready left from the earlier load must be gone first
    @(posedge mclk);
    check(flash_load_req, 1'b1, "load request");
    wait_for(2, 0);
    check(replicate_rows, 1'b0, "column replication");
    ptn.pulse_advance();
    repeat (3) @(posedge mclk);
    check(pattern_ready_out, 1'b0, "ready drop");
    wait_for(0, 1);
    check(ft_rise_cyc - ev_cyc, l0 + rows[4][5], "set trigger delay");
    ptn.pulse_advance();
    wait_for(2, 0);
    repeat (40) @(posedge mclk);
    check(lit_n, 1, "advance while busy");
    wait_for(3, 0);
    ptn.pulse_advance();
    wait_for(0, 2);
    wait_for(2, 0);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    check({flash_load_req, frame_trigger_out, pattern_trigger_out, pattern_ready_out, illum_en,
      mirror_on, mirror_plane, replicate_rows}, 0, "outputs in reset");
    check(line_value, 0, "line in reset");
    nrst <= 1'b1;
    foreach (rst_tab[i]) begin
      reg_read(8'(rst_tab[i][0]), d);
      check(d, rst_tab[i][1], "reset value");
    end
    stop_test();
  end
endmodule
`default_nettype wire
